// file: logic/cimk_consts.vh
// Constants for the chroma interpolation, colour matrix and KEY scaler stage.
`ifndef CIMK_CONSTS_VH
`define CIMK_CONSTS_VH

`define CIMK_IN_W 11
`define CIMK_Q_W 13
`define CIMK_Q_FRAC 2
`define CIMK_COEF_W 13
`define CIMK_COEF_FRAC 10
`define CIMK_PROD_W 26
`define CIMK_SUM_W 28
`define CIMK_OUT_W 14
`define CIMK_FIFO_DEPTH 16
`define CIMK_PIPE_LAT 6

`define CIMK_FIL_DROP_W10 2
`define CIMK_FIL_DROP_W8 4
`define CIMK_MTX_DROP_W10 12
`define CIMK_MTX_DROP_W8 14
`define CIMK_MTX_BITS_W10 13
`define CIMK_MTX_BITS_W8 11
`define CIMK_KEY_BITS_W10 11
`define CIMK_KEY_BITS_W8 9

`define CIMK_OFS_LUMA 64
`define CIMK_OFS_CHROMA 512
`define CIMK_OFS_SEL_STUDIO 2'h0
`define CIMK_OFS_SEL_ALL64 2'h1
`define CIMK_OFS_SEL_NONE 2'h2
`define CIMK_OFS_SEL_CHROMA 2'h3

`endif

// file: logic/cimk_fifo.v
// Output buffer: a small FIFO whose read data come from a register.
`timescale 1ns/1ps
`default_nettype none
module cimk_fifo #(
  parameter W = 56,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock,
  input wire resetn,
  input wire in_valid,
  output reg in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] count;
  wire push;
  wire load;
  wire [AW:0] next_count;

  assign push = in_valid & in_ready;
  // The output register refills as soon as it is empty or being taken.
  assign load = (count != {(AW+1){1'b0}}) & (~out_valid | out_ready);
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  always @(posedge clock) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
    end else begin
      if (push) begin
        wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (load) begin
        rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
        out_data <= mem[rptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count <= next_count;
      in_ready <= (next_count != DEPTH[AW:0]);
    end
  end
endmodule // cimk_fifo
`default_nettype wire

// file: logic/cimk_scaler.v
// Chroma interpolation filter, 3x3 colour matrix, KEY scaler and output offset stage.
`timescale 1ns/1ps
`default_nettype none
`include "cimk_consts.vh"
module cimk_scaler #(
  parameter IN_W = `CIMK_IN_W,
  parameter FIFO_DEPTH = `CIMK_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  input wire clock,
  input wire resetn,
  input wire filter_bypass,
  input wire filter_round_mode,
  input wire output_width_select,
  input wire output_offset_select_hi,
  input wire output_offset_select_lo,
  input wire [12:0] matrix_coefficient_11,
  input wire [12:0] matrix_coefficient_12,
  input wire [12:0] matrix_coefficient_13,
  input wire [12:0] matrix_coefficient_21,
  input wire [12:0] matrix_coefficient_22,
  input wire [12:0] matrix_coefficient_23,
  input wire [12:0] matrix_coefficient_31,
  input wire [12:0] matrix_coefficient_32,
  input wire [12:0] matrix_coefficient_33,
  input wire [12:0] key_scale_coefficient,
  input wire in_valid,
  output wire in_ready,
  input wire in_cosited,
  input wire [IN_W-1:0] in_luma,
  input wire [IN_W-1:0] in_cb,
  input wire [IN_W-1:0] in_cr,
  input wire [IN_W-1:0] in_key,
  output wire out_valid,
  input wire out_ready,
  output wire [13:0] out_luma,
  output wire [13:0] out_cb,
  output wire [13:0] out_cr,
  output wire [13:0] out_key
);
  localparam QW = `CIMK_Q_W;
  localparam CW = `CIMK_COEF_W;
  localparam PW = `CIMK_PROD_W;
  localparam SW = `CIMK_SUM_W;
  localparam OW = `CIMK_OUT_W;
  localparam FW = 4 * OW;
  // Step sizes, limits and offsets sized to the signals that carry them.
  localparam [3:0] FIL_DROP_W10 = `CIMK_FIL_DROP_W10;
  localparam [3:0] FIL_DROP_W8 = `CIMK_FIL_DROP_W8;
  localparam [3:0] MTX_DROP_W10 = `CIMK_MTX_DROP_W10;
  localparam [3:0] MTX_DROP_W8 = `CIMK_MTX_DROP_W8;
  localparam [3:0] MTX_BITS_W10 = `CIMK_MTX_BITS_W10;
  localparam [3:0] MTX_BITS_W8 = `CIMK_MTX_BITS_W8;
  localparam [3:0] KEY_BITS_W10 = `CIMK_KEY_BITS_W10;
  localparam [3:0] KEY_BITS_W8 = `CIMK_KEY_BITS_W8;
  localparam [3:0] PIPE_LAT = `CIMK_PIPE_LAT;
  localparam [OW-1:0] OFS_LUMA = `CIMK_OFS_LUMA;
  localparam [OW-1:0] OFS_CHROMA = `CIMK_OFS_CHROMA;

  // Filter-section rounding: mode 0 keeps the fraction, mode 1 rounds to the data LSB.
  function [QW-1:0] fil_round;
    input [QW-1:0] v;
    input mode;
    input wsel;
    reg signed [QW:0] t;
    reg [3:0] drop;
    begin
      drop = wsel ? FIL_DROP_W8 : FIL_DROP_W10;
      t = {v[QW-1], v};
      if (mode) begin
        t = t + (14'sh1 <<< (drop - 4'h1));
        t = (t >>> drop) <<< drop;
      end
      if (t > 14'sh0FFF) begin
        fil_round = 13'h0FFF;
      end else if (t < -14'sh1000) begin
        fil_round = 13'h1000;
      end else begin
        fil_round = t[QW-1:0];
      end
    end
  endfunction

  // Round to nearest by adding half an LSB, shift, then saturate to the given width.
  function [QW-1:0] rnd_sat;
    input [SW-1:0] v;
    input [3:0] drop;
    input [3:0] bits;
    reg signed [SW:0] t;
    reg signed [SW:0] mx;
    reg signed [SW:0] mn;
    begin
      t = $signed({v[SW-1], v}) + (29'sh1 <<< (drop - 4'h1));
      t = t >>> drop;
      mx = (29'sh1 <<< (bits - 4'h1)) - 29'sh1;
      mn = -mx - 29'sh1;
      if (t > mx) begin
        t = mx;
      end else if (t < mn) begin
        t = mn;
      end
      rnd_sat = t[QW-1:0];
    end
  endfunction

  // Offset for a channel: 0 luma, 1 and 2 colour difference, 3 KEY.
  function [OW-1:0] offset_for;
    input [1:0] sel;
    input [1:0] ch;
    reg chroma;
    begin
      chroma = (ch == 2'h1) || (ch == 2'h2);
      case (sel)
        `CIMK_OFS_SEL_STUDIO: offset_for = chroma ? OFS_CHROMA : OFS_LUMA;
        `CIMK_OFS_SEL_ALL64: offset_for = OFS_LUMA;
        `CIMK_OFS_SEL_NONE: offset_for = {OW{1'b0}};
        `CIMK_OFS_SEL_CHROMA: offset_for = chroma ? OFS_CHROMA : {OW{1'b0}};
        default: offset_for = {OW{1'b0}};
      endcase
    end
  endfunction

  wire adv;
  wire shift;
  wire fifo_ready;
  wire [FW-1:0] fifo_out;
  wire [CW-1:0] coef [0:8];

  assign coef[0] = matrix_coefficient_11;
  assign coef[1] = matrix_coefficient_12;
  assign coef[2] = matrix_coefficient_13;
  assign coef[3] = matrix_coefficient_21;
  assign coef[4] = matrix_coefficient_22;
  assign coef[5] = matrix_coefficient_23;
  assign coef[6] = matrix_coefficient_31;
  assign coef[7] = matrix_coefficient_32;
  assign coef[8] = matrix_coefficient_33;

  // The whole pipeline moves together only when the buffer can take a word.
  assign adv = fifo_ready;
  assign in_ready = fifo_ready;
  assign shift = adv & in_valid;

  // Three-sample window; the middle sample is the one being produced.
  reg [IN_W-1:0] win_y [0:2];
  reg [IN_W-1:0] win_cb [0:2];
  reg [IN_W-1:0] win_cr [0:2];
  reg [IN_W-1:0] win_k [0:2];
  reg [2:0] win_cos;
  reg [2:0] win_val;

  reg [QW-1:0] fil [0:3];
  reg fil_valid;
  reg [PW-1:0] prod [0:8];
  reg [PW-1:0] kprod;
  reg prod_valid;
  reg [QW-1:0] rnd [0:3];
  reg rnd_valid;
  reg [FW-1:0] ofs_word;
  reg ofs_valid;

  reg bypass_seen;
  reg [3:0] blank_count;
  wire bypass_flip;
  wire blanking;

  // A flip is seen for exactly one cycle, because the seen copy follows every edge.
  assign bypass_flip = (bypass_seen != filter_bypass);
  assign blanking = bypass_flip | (blank_count != 4'h0);

  reg [QW-1:0] next_cb;
  reg [QW-1:0] next_cr;
  reg [IN_W:0] sum_cb;
  reg [IN_W:0] sum_cr;
  reg [SW-1:0] acc;
  reg [3:0] mdrop;
  reg [3:0] mbits;
  reg [3:0] kbits;
  integer i;
  integer j;

  // Widen a raw sample to the filter's fixed-point format without changing its value.
  function [QW-1:0] to_q;
    input [IN_W-1:0] s;
    begin
      to_q = {s, {`CIMK_Q_FRAC{1'b0}}};
    end
  endfunction

  always @(posedge clock) begin
    if (!resetn) begin
      win_cos <= 3'h0;
      win_val <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        win_y[i] <= {IN_W{1'b0}};
        win_cb[i] <= {IN_W{1'b0}};
        win_cr[i] <= {IN_W{1'b0}};
        win_k[i] <= {IN_W{1'b0}};
      end
    end else if (shift) begin
      win_y[0] <= in_luma;
      win_cb[0] <= in_cb;
      win_cr[0] <= in_cr;
      win_k[0] <= in_key;
      win_cos <= {win_cos[1:0], in_cosited};
      win_val <= {win_val[1:0], 1'b1};
      for (i = 1; i < 3; i = i + 1) begin
        win_y[i] <= win_y[i-1];
        win_cb[i] <= win_cb[i-1];
        win_cr[i] <= win_cr[i-1];
        win_k[i] <= win_k[i-1];
      end
    end
  end

  // Interpolated colour difference for a sample that has no co-sited chroma.
  always @* begin
    sum_cb = {win_cb[0][IN_W-1], win_cb[0]} + {win_cb[2][IN_W-1], win_cb[2]};
    sum_cr = {win_cr[0][IN_W-1], win_cr[0]} + {win_cr[2][IN_W-1], win_cr[2]};
    if (filter_bypass || win_cos[1]) begin
      next_cb = to_q(win_cb[1]);
      next_cr = to_q(win_cr[1]);
    end else begin
      next_cb = {sum_cb, 1'b0};
      next_cr = {sum_cr, 1'b0};
    end
  end

  // Bypassed or not, every sample leaves through the same register. Round mode 1
  // would touch bypassed data, so the configuring side keeps mode 0 then.
  always @(posedge clock) begin
    if (!resetn) begin
      fil_valid <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        fil[i] <= {QW{1'b0}};
      end
    end else if (adv) begin
      // Results formed across a bypass change mix both modes, so they never leave.
      fil_valid <= shift & win_val[1] & ~blanking;
      if (shift) begin
        fil[0] <= to_q(win_y[1]);
        fil[1] <= fil_round(next_cb, filter_round_mode, output_width_select);
        fil[2] <= fil_round(next_cr, filter_round_mode, output_width_select);
        fil[3] <= to_q(win_k[1]);
      end
    end
  end

  // Full-width signed products; coefficient bit 12 is the sign, worth minus four.
  always @(posedge clock) begin
    if (!resetn) begin
      prod_valid <= 1'b0;
      kprod <= {PW{1'b0}};
      for (i = 0; i < 9; i = i + 1) begin
        prod[i] <= {PW{1'b0}};
      end
    end else if (adv) begin
      prod_valid <= fil_valid;
      for (i = 0; i < 3; i = i + 1) begin
        for (j = 0; j < 3; j = j + 1) begin
          prod[i*3+j] <= $signed(fil[j]) * $signed(coef[i*3+j]);
        end
      end
      kprod <= $signed(fil[3]) * $signed(key_scale_coefficient);
    end
  end

  // Sums carry every product bit; matrix results are rounded once, here, after the sums.
  always @* begin
    mdrop = output_width_select ? MTX_DROP_W8 : MTX_DROP_W10;
    mbits = output_width_select ? MTX_BITS_W8 : MTX_BITS_W10;
    kbits = output_width_select ? KEY_BITS_W8 : KEY_BITS_W10;
  end

  always @(posedge clock) begin
    if (!resetn) begin
      rnd_valid <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        rnd[i] <= {QW{1'b0}};
      end
    end else if (adv) begin
      rnd_valid <= prod_valid;
      for (i = 0; i < 3; i = i + 1) begin
        rnd[i] <= rnd_sat({{2{prod[i*3][PW-1]}}, prod[i*3]}
                          + {{2{prod[i*3+1][PW-1]}}, prod[i*3+1]}
                          + {{2{prod[i*3+2][PW-1]}}, prod[i*3+2]},
                          mdrop, mbits);
      end
      rnd[3] <= rnd_sat({{2{kprod[PW-1]}}, kprod}, mdrop, kbits);
    end
  end

  // Offsets are added at full width; clipping happens earlier, in rnd_sat, and nothing clips after this.
  always @(posedge clock) begin
    if (!resetn) begin
      ofs_valid <= 1'b0;
      ofs_word <= {FW{1'b0}};
    end else if (adv) begin
      ofs_valid <= rnd_valid;
      for (i = 0; i < 4; i = i + 1) begin
        ofs_word[i*OW +: OW] <= {rnd[i][QW-1], rnd[i]}
          + offset_for({output_offset_select_hi, output_offset_select_lo}, i[1:0]);
      end
    end
  end

  // A bypass change leaves stale samples in flight; drop a pipeline's worth.
  always @(posedge clock) begin
    if (!resetn) begin
      bypass_seen <= 1'b0;
      blank_count <= 4'h0;
    end else begin
      bypass_seen <= filter_bypass;
      // The result formed on the change edge is the first of the dropped ones.
      if (bypass_flip) begin
        blank_count <= shift ? PIPE_LAT - 4'h1 : PIPE_LAT;
      end else if (shift && (blank_count != 4'h0)) begin
        blank_count <= blank_count - 4'h1;
      end
    end
  end

  cimk_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(ofs_valid & adv),
    .in_ready(fifo_ready),
    .in_data(ofs_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );

  assign out_luma = fifo_out[0*OW +: OW];
  assign out_cb = fifo_out[1*OW +: OW];
  assign out_cr = fifo_out[2*OW +: OW];
  assign out_key = fifo_out[3*OW +: OW];
endmodule // cimk_scaler
`default_nettype wire

// file: dv/cimk_sink.sv
// Downstream partner model: takes output words and stalls one cycle in four.
`timescale 1ns/1ps
`default_nettype none
module cimk_sink (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hold,
  output logic out_ready
);
  logic [1:0] phase;
  // Regular stalls keep the output register and the FIFO busy, not just pass-through.
  always @(posedge clock) begin
    if (!resetn) begin
      phase <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      out_ready <= !hold && phase != 2'h3;
    end
  end
endmodule // cimk_sink
`default_nettype wire

// file: dv/cimk_checker.sv
// Checker: output stability, reset behaviour and rounding ranges at the stage's ports.
`timescale 1ns/1ps
`default_nettype none
module cimk_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic output_width_select,
  input wire logic output_offset_select_hi,
  input wire logic output_offset_select_lo,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [13:0] out_luma,
  input wire logic [13:0] out_cb,
  input wire logic [13:0] out_cr,
  input wire logic [13:0] out_key
);
  int oy, oc, y, b, r, k;
  // Offsets are taken off first, so one range serves every offset set.
  assign oy = output_offset_select_hi ? 0 : 64;
  assign oc = {output_offset_select_hi, output_offset_select_lo} == 2'h1 ? 64 :
    ((oy == 64 || output_offset_select_lo) ? 512 : 0);
  assign y = $signed(out_luma) - oy;
  assign b = $signed(out_cb) - oc;
  assign r = $signed(out_cr) - oc;
  assign k = $signed(out_key) - oy;
  function automatic logic fits(input int v, input int m);
    return v >= -m - 1 && v <= m;
  endfunction
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_stall; out_valid && !out_ready; endsequence
  sequence s_release; $rose(resetn) ##1 1'b1; endsequence
  property p_hold; s_stall |=> out_valid && $stable({out_luma, out_cb, out_cr, out_key}); endproperty
  a_hold: assert property (p_hold) else $error("output word changed while stalled");
  property p_reset;
    @(posedge clock) disable iff (1'b0) !resetn |=> !out_valid && out_key == 14'h0000;
  endproperty
  a_reset: assert property (p_reset) else $error("output valid after reset");
  property p_ready; s_release |-> in_ready; endproperty
  a_ready: assert property (p_ready) else $error("input not ready after reset");
  property p_full; !in_ready && $past(resetn) |-> out_valid; endproperty
  a_full: assert property (p_full) else $error("input refused with empty buffer");
  property p_mtx_w0;
    out_valid && !output_width_select |-> fits(y, 4095) && fits(b, 4095) && fits(r, 4095);
  endproperty
  a_mtx_w0: assert property (p_mtx_w0) else $error("matrix output beyond 13 bits");
  property p_mtx_w1;
    out_valid && output_width_select |-> fits(y, 1023) && fits(b, 1023) && fits(r, 1023);
  endproperty
  a_mtx_w1: assert property (p_mtx_w1) else $error("matrix output beyond 11 bits");
  property p_key_w0; out_valid && !output_width_select |-> fits(k, 1023); endproperty
  a_key_w0: assert property (p_key_w0) else $error("key output beyond 11 bits");
  property p_key_w1; out_valid && output_width_select |-> fits(k, 255); endproperty
  a_key_w1: assert property (p_key_w1) else $error("key output beyond 9 bits");
endmodule // cimk_checker
bind cimk_scaler cimk_checker cimk_checker_inst (.clock(clock), .resetn(resetn),
  .output_width_select(output_width_select), .output_offset_select_hi(output_offset_select_hi),
  .output_offset_select_lo(output_offset_select_lo), .in_ready(in_ready), .out_valid(out_valid),
  .out_ready(out_ready), .out_luma(out_luma), .out_cb(out_cb), .out_cr(out_cr), .out_key(out_key));
`default_nettype wire

// file: dv/tb_top.sv
// Testbench: sample stream scenarios for the colour stage with a stalling consumer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, resetn = 1'b0, filter_bypass = 1'b1, filter_round_mode = 1'b0;
  logic output_width_select = 1'b0, output_offset_select_hi = 1'b1, output_offset_select_lo = 1'b0;
  logic in_valid = 1'b0, in_cosited = 1'b1, hold = 1'b0;
  logic [10:0] in_luma = 11'h000, in_cb = 11'h000, in_cr = 11'h000, in_key = 11'h000;
  logic [12:0] cf [0:9];
  wire logic in_ready, out_valid, out_ready;
  wire logic [13:0] out_luma, out_cb, out_cr, out_key;
  logic [55:0] lw;
  logic [55:0] q [$];
  int n_errors = 0, tests_run = 0, n_acc = 0, n_out = 0, cyc = 0, i, j;
  always #2 clock = ~clock;
  cimk_scaler cimk_scaler_inst (.matrix_coefficient_11(cf[0]), .matrix_coefficient_12(cf[1]),
    .matrix_coefficient_13(cf[2]), .matrix_coefficient_21(cf[3]), .matrix_coefficient_22(cf[4]),
    .matrix_coefficient_23(cf[5]), .matrix_coefficient_31(cf[6]), .matrix_coefficient_32(cf[7]),
    .matrix_coefficient_33(cf[8]), .key_scale_coefficient(cf[9]), .*);
  cimk_sink cimk_sink_inst (.clock(clock), .resetn(resetn), .hold(hold), .out_ready(out_ready));
  // Handshakes are sampled mid-cycle, where registered outputs are settled.
  always @(negedge clock) begin
    if (in_valid && in_ready) n_acc++;
    if (out_valid && out_ready) begin
      lw = {out_luma, out_cb, out_cr, out_key};
      q.push_back(lw);
      n_out++;
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      complete_run;
    end
  end
  task complete_run;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [55:0] got, input logic [55:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function integer rnd(input integer s, input logic k);
    integer v, m;
    v = output_width_select ? (s + 2048) >>> 12 : (s + 512) >>> 10;
    m = (k ^ output_width_select) ? 1023 : (k ? 255 : 4095);
    if (v > m) v = m;
    if (v < -m - 1) v = -m - 1;
    rnd = v;
  endfunction
  function logic [55:0] expw(input integer y, input integer b, input integer r, input integer k);
    integer oy, oc;
    oy = output_offset_select_hi ? 0 : 64;
    oc = output_offset_select_lo ? (oy == 64 ? 64 : 512) : (oy == 64 ? 512 : 0);
    expw[55:42] = rnd(y * $signed(cf[0]) + b * $signed(cf[1]) + r * $signed(cf[2]), 1'b0) + oy;
    expw[41:28] = rnd(y * $signed(cf[3]) + b * $signed(cf[4]) + r * $signed(cf[5]), 1'b0) + oc;
    expw[27:14] = rnd(y * $signed(cf[6]) + b * $signed(cf[7]) + r * $signed(cf[8]), 1'b0) + oc;
    expw[13:0] = rnd(k * $signed(cf[9]), 1'b1) + oy;
  endfunction
  task push(input integer y, input integer b, input integer r, input integer k, input logic c);
    in_luma <= y[10:0];
    in_cb <= b[10:0];
    in_cr <= r[10:0];
    in_key <= k[10:0];
    in_cosited <= c;
    in_valid <= 1'b1;
    @(negedge clock);
    while (in_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
  endtask
  task drain;
    in_valid <= 1'b0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    while (out_valid !== 1'b0) @(negedge clock);
    @(posedge clock);
  endtask
  // Ten equal samples cover the dropped results and leave settled words behind.
  task burst(input integer y, input integer b, input integer r, input integer k);
    repeat (10) push(y, b, r, k, 1'b1);
    drain;
  endtask
  task cfg(input logic fb, input logic fr, input logic w, input logic [1:0] s,
    input logic [12:0] d, input logic [12:0] o);
    filter_bypass <= fb;
    filter_round_mode <= fr;
    output_width_select <= w;
    {output_offset_select_hi, output_offset_select_lo} <= s;
    for (i = 0; i < 10; i++) cf[i] <= (i % 4 == 0 || i == 9) ? d : o;
  endtask
  task t_ident;
    for (j = 0; j < 4; j++) begin
      cfg(1'b1, 1'b0, 1'b0, j[1:0], 13'h0400, 13'h0000);
      burst(100, -200, 300, -5);
      chk(lw, expw(100, -200, 300, -5));
    end
  endtask
  task t_round;
    cfg(1'b1, 1'b0, 1'b1, 2'h2, 13'h0400, 13'h0000);
    burst(2, -2, 6, 1023);
    chk(lw, expw(2, -2, 6, 1023));
  endtask
  task t_width;
    for (j = 0; j < 2; j++) begin
      cfg(1'b0, 1'b1, j[0], 2'h1, 13'h0400, 13'h0000);
      burst(400, -400, 1020, -8);
      chk(lw, expw(400, -400, 1020, -8));
    end
  endtask
  // A half step between chroma neighbours shows whether the filter rounds first.
  task t_fround;
    cfg(1'b0, 1'b1, 1'b0, 2'h2, 13'h0800, 13'h0000);
    push(0, 1, -1, 0, 1'b1);
    push(0, 0, 0, 0, 1'b0);
    push(0, 2, -2, 0, 1'b1);
    push(0, 0, 0, 0, 1'b1);
    drain;
    chk(lw, expw(0, 2, -1, 0));
  endtask
  task t_matrix;
    for (j = 0; j < 2; j++) begin
      cfg(1'b0, 1'b0, j[0], 2'h0, 13'h0000, 13'h0000);
      @(posedge clock);
      for (i = 0; i < 10; i++) cf[i] <= 13'h0233 * (i + 1);
      burst(1023, -1024, 517, -1024);
      chk(lw, expw(1023, -1024, 517, -1024));
    end
  endtask
  task t_interp;
    for (j = 0; j < 2; j++) begin
      cfg(j[0], 1'b0, 1'b0, 2'h2, 13'h0400, 13'h0000);
      burst(40, 100, -100, 5);
      q.delete();
      push(40, 100, -100, 5, 1'b1);
      push(50, 999, 7, 5, 1'b0);
      push(40, 300, -300, 5, 1'b1);
      push(40, 1, 1, 5, 1'b0);
      push(40, 300, -300, 5, 1'b1);
      drain;
      chk(q[3], j ? expw(50, 999, 7, 5) : expw(50, 200, -200, 5));
    end
  endtask
  task t_drop;
    j = n_acc - n_out;
    cfg(1'b0, 1'b0, 1'b0, 2'h3, 13'h0400, 13'h0000);
    burst(7, 8, 9, 10);
    chk(56'(n_acc - n_out - j), 56'h6);
    chk(lw, expw(7, 8, 9, 10));
  endtask
  task t_fill;
    j = n_acc - n_out;
    hold <= 1'b1;
    in_valid <= 1'b1;
    repeat (40) @(posedge clock);
    @(negedge clock);
    chk({55'h0, in_ready}, 56'h0);
    @(posedge clock);
    in_valid <= 1'b0;
    hold <= 1'b0;
    drain;
    chk(56'(n_acc - n_out - j), 56'h0);
  endtask
  initial begin
    for (i = 0; i < 10; i++) cf[i] = (i % 4 == 0 || i == 9) ? 13'h0400 : 13'h0000;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    t_ident;
    t_round;
    t_width;
    t_fround;
    t_matrix;
    t_interp;
    t_drop;
    t_fill;
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
